/* File: rtl/psda_bridge.sv */
// Program space data access bridge: table ops and visibility window
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module psda_bridge
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Avalon-MM slave
   input wire logic [psda_pkg::PSDA_AW-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Core request: one-cycle pulse, held data until done
   input wire logic req_in,
   input wire logic req_table_in,
   input wire logic req_write_in,
   input wire logic req_high_in,
   input wire logic req_byte_in,
   input wire logic req_mov_in,
   input wire logic [15:0] req_ea_in,
   input wire logic [15:0] req_wdata_in,
   output logic done_out,
   output logic [15:0] rdata_out,
   output logic stall_out,
   output logic [1:0] extra_cycles_out,
   output logic window_hit_out,
   // Program memory side
   output logic pm_read_out,
   output logic pm_write_out,
   output logic [23:0] pm_addr_out,
   output logic [23:0] pm_wdata_out,
   output logic [2:0] pm_lane_out,
   input wire logic [23:0] pm_rdata_in,
   input wire logic pm_valid_in
);
   logic [7:0] vis_page_q;
   logic [7:0] tbl_page_q;
   logic [15:0] core_ctrl_q;
   psda_pkg::psda_state_e state_q;
   logic hit_q;
   logic table_q;
   logic high_q;
   logic byte_q;
   logic sel_q;
   logic [15:0] pick_w;
   logic win_hit_d;
   logic [23:0] addr_d;
   logic bus_busy_q;

   // Window decode; table ops never use it
   // Window is read-only: a write would wait forever for memory
   always_comb
   begin
      win_hit_d = req_ea_in[psda_pkg::PSDA_EA_MSB] && !req_write_in &&
                  core_ctrl_q[psda_pkg::PSDA_WIN_EN_BIT] && !req_table_in;
      if (req_table_in)
         addr_d = {tbl_page_q, req_ea_in[15:1], 1'b0};
      else
         addr_d = {1'b0, vis_page_q, req_ea_in[14:0]};
   end

   psda_byte_pick u_pick
   (
      .word_in(pm_rdata_in),
      .high_in(high_q),
      .byte_in(byte_q),
      .sel_in(sel_q),
      .data_out(pick_w)
   );

   // Request sequencing
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         state_q <= psda_pkg::PSDA_IDLE;
         hit_q <= 1'b0;
         table_q <= 1'b0;
         high_q <= 1'b0;
         byte_q <= 1'b0;
         sel_q <= 1'b0;
         pm_read_out <= 1'b0;
         pm_write_out <= 1'b0;
         pm_addr_out <= 24'h000000;
         pm_wdata_out <= 24'h000000;
         pm_lane_out <= 3'h0;
         done_out <= 1'b0;
         rdata_out <= 16'h0000;
         stall_out <= 1'b0;
         extra_cycles_out <= 2'h0;
         window_hit_out <= 1'b0;
      end
      else
      begin
         done_out <= 1'b0;
         unique case (state_q)
            psda_pkg::PSDA_IDLE:
            begin
               if (req_in && (req_table_in || win_hit_d))
               begin
                  hit_q <= win_hit_d;
                  table_q <= req_table_in;
                  high_q <= req_table_in && req_high_in;
                  byte_q <= req_table_in && req_byte_in;
                  sel_q <= req_ea_in[0];
                  pm_addr_out <= addr_d;
                  pm_read_out <= !req_write_in;
                  pm_write_out <= req_write_in && req_table_in;
                  // Lanes: bit2 upper byte, bit1 mid, bit0 low
                  if (req_high_in)
                     pm_lane_out <= (req_byte_in && req_ea_in[0]) ? 3'h0 : 3'h4;
                  else if (req_byte_in)
                     pm_lane_out <= req_ea_in[0] ? 3'h2 : 3'h1;
                  else
                     pm_lane_out <= 3'h3;
                  if (req_high_in)
                     pm_wdata_out <= {req_wdata_in[7:0], 16'h0000};
                  else if (req_byte_in)
                     pm_wdata_out <= {8'h00, req_wdata_in[7:0], req_wdata_in[7:0]};
                  else
                     pm_wdata_out <= {8'h00, req_wdata_in};
                  stall_out <= 1'b1;
                  window_hit_out <= win_hit_d;
                  extra_cycles_out <= win_hit_d ?
                     (req_mov_in ? psda_pkg::PSDA_EXTRA_MOV : psda_pkg::PSDA_EXTRA_OTHER)
                     : 2'h0;
                  state_q <= psda_pkg::PSDA_FETCH;
               end
            end
            psda_pkg::PSDA_FETCH:
            begin
               if (pm_valid_in)
               begin
                  pm_read_out <= 1'b0;
                  pm_write_out <= 1'b0;
                  pm_lane_out <= 3'h0;
                  // Window returns the low word only
                  rdata_out <= hit_q ? pm_rdata_in[15:0] : pick_w;
                  state_q <= psda_pkg::PSDA_STRETCH;
               end
            end
            psda_pkg::PSDA_STRETCH:
            begin
               // Extra cycle for the second fetch slot
               done_out <= 1'b1;
               stall_out <= 1'b0;
               window_hit_out <= 1'b0;
               state_q <= psda_pkg::PSDA_IDLE;
            end
            default:
               state_q <= psda_pkg::PSDA_IDLE;
         endcase
      end
   end

   // Register bus: one wait cycle per access
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
         bus_busy_q <= 1'b0;
      else
         bus_busy_q <= (avs_read_in || avs_write_in) && !bus_busy_q;
   end

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
         avs_waitrequest_out <= 1'b1;
      else
         avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !bus_busy_q);
   end

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         vis_page_q <= psda_pkg::PSDA_RST_VIS_PAGE;
         tbl_page_q <= psda_pkg::PSDA_RST_TBL_PAGE;
         core_ctrl_q <= psda_pkg::PSDA_RST_CORE_CTRL;
      end
      else if (avs_write_in && bus_busy_q)
      begin
         unique case (avs_address_in)
            psda_pkg::PSDA_OFF_VIS_PAGE:
               if (avs_byteenable_in[0])
                  vis_page_q <= avs_writedata_in[7:0];
            psda_pkg::PSDA_OFF_TBL_PAGE:
               if (avs_byteenable_in[0])
                  tbl_page_q <= avs_writedata_in[7:0];
            psda_pkg::PSDA_OFF_CORE_CTRL:
            begin
               if (avs_byteenable_in[0])
                  core_ctrl_q[7:0] <= avs_writedata_in[7:0];
               if (avs_byteenable_in[1])
                  core_ctrl_q[15:8] <= avs_writedata_in[15:8];
            end
            default:
               ;
         endcase
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
         avs_readdata_out <= 32'h00000000;
      else if (avs_read_in && !bus_busy_q)
      begin
         unique case (avs_address_in)
            psda_pkg::PSDA_OFF_VIS_PAGE:
               avs_readdata_out <= {24'h000000, vis_page_q};
            psda_pkg::PSDA_OFF_TBL_PAGE:
               avs_readdata_out <= {24'h000000, tbl_page_q};
            psda_pkg::PSDA_OFF_CORE_CTRL:
               avs_readdata_out <= {16'h0000, core_ctrl_q};
            psda_pkg::PSDA_OFF_STATUS:
               avs_readdata_out <= {27'h0000000, tbl_page_q[psda_pkg::PSDA_CFG_BIT],
                                    hit_q, table_q, state_q};
            default:
               avs_readdata_out <= 32'h00000000;
         endcase
      end
   end

   // Checks
   window_gate_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_IDLE && req_in && !req_table_in &&
       !core_ctrl_q[psda_pkg::PSDA_WIN_EN_BIT]) |=> !pm_read_out)
      else $error("window used while disabled");
   window_addr_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_IDLE && req_in && win_hit_d) |=>
      pm_addr_out == {1'b0, $past(vis_page_q), $past(req_ea_in[14:0])})
      else $error("window address wrong");
   table_addr_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_IDLE && req_in && req_table_in) |=>
      pm_addr_out[23:16] == $past(tbl_page_q) && !pm_addr_out[0])
      else $error("table address wrong");
   table_step_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_IDLE && req_in && req_table_in) |=>
      pm_addr_out[15:1] == $past(req_ea_in[15:1]))
      else $error("table word step wrong");
   byte_sel_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_IDLE && req_in && req_table_in) |=>
      sel_q == $past(req_ea_in[0]))
      else $error("byte selector wrong");
   upper_lane_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_IDLE && req_in && !req_high_in) |=> !pm_lane_out[2])
      else $error("upper byte reached by low op");
   table_no_win_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_IDLE && req_in && req_table_in) |=> !window_hit_out)
      else $error("window used by table op");
   stretch_done_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_FETCH && pm_valid_in) |=> ##1 done_out)
      else $error("done not one cycle after data");
   stall_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      state_q == psda_pkg::PSDA_FETCH |-> stall_out)
      else $error("stall dropped during fetch");
   done_pulse_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      done_out |=> !done_out)
      else $error("done longer than one cycle");
   window_data_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_FETCH && pm_valid_in && hit_q) |=>
      rdata_out == $past(pm_rdata_in[15:0]))
      else $error("window data wrong");
   high_word_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_FETCH && pm_valid_in && table_q && high_q && !byte_q) |=>
      rdata_out == {8'h00, $past(pm_rdata_in[23:16])})
      else $error("high word read wrong");
   phantom_zero_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_FETCH && pm_valid_in && high_q && byte_q && sel_q) |=>
      rdata_out == 16'h0000)
      else $error("phantom byte nonzero");
   high_byte_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_FETCH && pm_valid_in && high_q && byte_q && !sel_q) |=>
      rdata_out == {8'h00, $past(pm_rdata_in[23:16])})
      else $error("high byte read wrong");
   low_word_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_FETCH && pm_valid_in && table_q && !high_q && !byte_q) |=>
      rdata_out == $past(pm_rdata_in[15:0]))
      else $error("low word read wrong");
   byte_low_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_FETCH && pm_valid_in && table_q && !high_q && byte_q) |=>
      rdata_out == {8'h00, ($past(sel_q) ? $past(pm_rdata_in[15:8]) :
                            $past(pm_rdata_in[7:0]))})
      else $error("low byte read wrong");
   extra_mov_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_IDLE && req_in && win_hit_d && req_mov_in) |=>
      extra_cycles_out == psda_pkg::PSDA_EXTRA_MOV)
      else $error("extra cycle count wrong");
   extra_other_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state_q == psda_pkg::PSDA_IDLE && req_in && win_hit_d && !req_mov_in) |=>
      extra_cycles_out == psda_pkg::PSDA_EXTRA_OTHER)
      else $error("extra cycle count wrong");
   cover_window_c: cover property (@(posedge clock_in) window_hit_out && done_out);
   cover_table_c: cover property (@(posedge clock_in) table_q && done_out);
   cover_write_c: cover property (@(posedge clock_in) pm_write_out && pm_valid_in);
   cover_phantom_c: cover property (@(posedge clock_in) high_q && byte_q && sel_q && done_out);
   cover_other_c: cover property (@(posedge clock_in)
      window_hit_out && extra_cycles_out == psda_pkg::PSDA_EXTRA_OTHER);
endmodule
`default_nettype wire

/* File: rtl/psda_byte_pick.sv */
// Byte and word steering of a 24-bit program word onto 16-bit data
`timescale 1ns/1ps
`default_nettype none
module psda_byte_pick
(
   input wire logic [23:0] word_in,
   input wire logic high_in,
   input wire logic byte_in,
   input wire logic sel_in,
   output logic [15:0] data_out
);
   always_comb
   begin
      if (!high_in && !byte_in)
         data_out = word_in[15:0];
      else if (!high_in)
         data_out = {8'h00, sel_in ? word_in[15:8] : word_in[7:0]};
      else if (!byte_in)
         data_out = {8'h00, word_in[23:16]};
      else
         data_out = {8'h00, sel_in ? 8'h00 : word_in[23:16]};
   end
endmodule
`default_nettype wire

/* File: rtl/psda_pkg.sv */
// Constants and types for the program space data access bridge
package psda_pkg;
   localparam int PSDA_AW = 4;
   localparam logic [3:0] PSDA_OFF_VIS_PAGE = 4'h0;
   localparam logic [3:0] PSDA_OFF_TBL_PAGE = 4'h4;
   localparam logic [3:0] PSDA_OFF_CORE_CTRL = 4'h8;
   localparam logic [3:0] PSDA_OFF_STATUS = 4'hC;
   localparam logic [7:0] PSDA_RST_VIS_PAGE = 8'h00;
   localparam logic [7:0] PSDA_RST_TBL_PAGE = 8'h00;
   localparam logic [15:0] PSDA_RST_CORE_CTRL = 16'h0000;
   localparam int PSDA_WIN_EN_BIT = 2;
   localparam int PSDA_CFG_BIT = 7;
   localparam int PSDA_EA_MSB = 15;
   localparam logic [1:0] PSDA_EXTRA_MOV = 2'h1;
   localparam logic [1:0] PSDA_EXTRA_OTHER = 2'h2;
   typedef enum logic [1:0]
   {
      PSDA_IDLE = 2'b00,
      PSDA_FETCH = 2'b01,
      PSDA_STRETCH = 2'b11
   } psda_state_e;
endpackage

/* File: verification/psda_bridge_tb.sv */
// Self-checking bench for the program space data access bridge
`timescale 1ns/1ps
`default_nettype none
module psda_bridge_tb;
   logic clock_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic [3:0] adr = 4'h0;
   logic rd = 1'h0;
   logic wr = 1'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdo, rdat;
   logic avs_wait, req = 1'h0, t = 1'h0, w = 1'h0, h = 1'h0, b = 1'h0, m = 1'h0;
   logic [15:0] ea = 16'h0, wd = 16'h0, rd16, crd;
   logic done, stall, hit, chit, pr, pw, pv;
   logic [1:0] ex, cex;
   logic [23:0] pa, pwd, prd, cpa, cpw;
   logic [2:0] pl, cpl;
   logic [3:0] dly = 4'h0;
   int failures = 0, num_checks = 0, cyc = 0;
   psda_bridge psda_bridge_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdo), .avs_waitrequest_out(avs_wait), .req_in(req), .req_table_in(t),
      .req_write_in(w), .req_high_in(h), .req_byte_in(b), .req_mov_in(m), .req_ea_in(ea),
      .req_wdata_in(wd), .done_out(done), .rdata_out(rd16), .stall_out(stall),
      .extra_cycles_out(ex), .window_hit_out(hit), .pm_read_out(pr), .pm_write_out(pw),
      .pm_addr_out(pa), .pm_wdata_out(pwd), .pm_lane_out(pl), .pm_rdata_in(prd), .pm_valid_in(pv));
   psda_pm_model psda_pm_model_i (.clock_in(clock_in), .read_in(pr), .write_in(pw), .addr_in(pa),
      .wdata_in(pwd), .lane_in(pl), .dly_in(dly), .rdata_out(prd), .valid_out(pv));
   always #5 clock_in = ~clock_in;
   task stop_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clock_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         stop_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input logic dir, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_in);
      rd <= !dir;
      wr <= dir;
      adr <= a;
      wdat <= d;
      do @(posedge clock_in); while (avs_wait !== 1'h0);
      rdat = rdo;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask
   // Kind bits: table, write, high, byte, move
   task op(input logic [4:0] k, input logic [15:0] a, input logic [15:0] d);
      int n;
      @(posedge clock_in);
      req <= 1'h1;
      {t, w, h, b, m} <= k;
      ea <= a;
      wd <= d;
      @(posedge clock_in);
      req <= 1'h0;
      do @(posedge clock_in); while (pr !== 1'h1 && pw !== 1'h1);
      cpa = pa;
      cpw = pwd;
      cpl = pl;
      // Hit flag drops with done, so take it while the access runs
      chit = hit;
      chk(32'(stall), 32'h1);
      n = 0;
      do
      begin
         @(posedge clock_in);
         n++;
      end
      while (done !== 1'h1);
      crd = rd16;
      cex = ex;
      chk(32'(stall), 32'h0);
      chk(32'(n), 32'(dly) + 32'h3);
      @(posedge clock_in);
      chk(32'(done), 32'h0);
   endtask
   // A request the bridge must not act on
   task refuse(input logic [4:0] k, input logic [15:0] a);
      logic bad;
      bad = 1'h0;
      @(posedge clock_in);
      req <= 1'h1;
      {t, w, h, b, m} <= k;
      ea <= a;
      @(posedge clock_in);
      req <= 1'h0;
      repeat (8)
      begin
         @(posedge clock_in);
         if (pr !== 1'h0 || pw !== 1'h0 || done !== 1'h0 || stall !== 1'h0)
            bad = 1'h1;
      end
      chk(32'(bad), 32'h0);
   endtask
   task table_reads;
      logic [23:0] p;
      logic [15:0] e, a;
      bus(1'h1, psda_pkg::PSDA_OFF_TBL_PAGE, 32'h85);
      for (int i = 0; i < 8; i++)
      begin
         a = 16'h1A30 + 16'(i);
         dly = 4'(i);
         op({1'h1, 1'h0, i[2], i[1], 1'h0}, a, 16'h0);
         p = psda_pm_model_i.pat({8'h85, a[15:1], 1'h0});
         chk(32'(cpa), 32'({8'h85, a[15:1], 1'h0}));
         e = i[2] ? {8'h00, p[23:16]} : p[15:0];
         if (i[1])
            e = i[0] ? {8'h00, e[15:8]} : {8'h00, e[7:0]};
         chk(32'(crd & (i[1] ? 16'h00FF : 16'hFFFF)), 32'(e));
         chk(32'(cex), 32'h0);
      end
   endtask
   task table_writes;
      dly = 4'h2;
      op(5'h1C, 16'h0104, 16'h005A);
      chk({21'h0, cpl, cpw[23:16]}, {21'h0, 3'h4, 8'h5A});
      op(5'h18, 16'h0104, 16'hBEEF);
      chk({13'h0, cpl, cpw[15:0]}, {13'h0, 3'h3, 16'hBEEF});
      op(5'h14, 16'h0104, 16'h0);
      chk(32'(crd), 32'h5A);
      op(5'h10, 16'h0104, 16'h0);
      chk(32'(crd), 32'hBEEF);
      op(5'h1A, 16'h0105, 16'h0077);
      chk({13'h0, cpl, cpw[15:0]}, {13'h0, 3'h2, 16'h7777});
      op(5'h10, 16'h0104, 16'h0);
      chk(32'(crd), 32'h77EF);
   endtask
   task window(input logic mv, input logic [15:0] a, input logic [23:0] xa, input logic [1:0] xe);
      logic [23:0] p;
      op({4'h0, mv}, a, 16'h0);
      p = psda_pm_model_i.pat(xa);
      chk(32'(cpa), 32'(xa));
      chk(32'(crd), 32'(p[15:0]));
      chk({29'h0, chit, cex}, {29'h0, 1'h1, xe});
   endtask
   initial
   begin
      repeat (3) @(posedge clock_in);
      rst_n_in <= 1'h1;
      bus(1'h0, psda_pkg::PSDA_OFF_VIS_PAGE, 32'h0);
      chk(rdat, 32'(psda_pkg::PSDA_RST_VIS_PAGE));
      bus(1'h0, psda_pkg::PSDA_OFF_TBL_PAGE, 32'h0);
      chk(rdat, 32'(psda_pkg::PSDA_RST_TBL_PAGE));
      bus(1'h0, psda_pkg::PSDA_OFF_CORE_CTRL, 32'h0);
      chk(rdat, 32'(psda_pkg::PSDA_RST_CORE_CTRL));
      refuse(5'h0, 16'h8000);
      table_reads();
      table_writes();
      bus(1'h1, psda_pkg::PSDA_OFF_VIS_PAGE, 32'h3C);
      bus(1'h0, psda_pkg::PSDA_OFF_VIS_PAGE, 32'h0);
      chk(rdat, 32'h3C);
      bus(1'h1, psda_pkg::PSDA_OFF_CORE_CTRL, 32'h4);
      dly = 4'h3;
      window(1'h1, 16'h8123, 24'h1E0123, 2'h1);
      dly = 4'h0;
      window(1'h0, 16'hFFFE, 24'h1E7FFE, 2'h2);
      op(5'h10, 16'h9124, 16'h0);
      chk({7'h0, chit, cpa}, {7'h0, 1'h0, 24'h859124});
      refuse(5'h08, 16'h8000);
      refuse(5'h0, 16'h7FFE);
      stop_test();
   end
endmodule
`default_nettype wire

/* File: verification/psda_pm_model.sv */
// Program memory model answering the bridge after a settable latency
`timescale 1ns/1ps
`default_nettype none
module psda_pm_model
(
   input wire logic clock_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [23:0] addr_in,
   input wire logic [23:0] wdata_in,
   input wire logic [2:0] lane_in,
   input wire logic [3:0] dly_in,
   output logic [23:0] rdata_out,
   output logic valid_out
);
   logic [23:0] mem [int];
   // User-space constants pad their upper byte uniformly
   function automatic logic [23:0] pat(input logic [23:0] a);
      return {a[23] ? a[7:0] ^ a[23:16] : {8{a[1]}}, a[15:0] ^ 16'h3C96};
   endfunction
   initial
   begin
      logic [23:0] w;
      valid_out = 1'h0;
      rdata_out = 24'h0;
      forever
      begin
         @(posedge clock_in);
         valid_out <= 1'h0;
         if (read_in || write_in)
         begin
            repeat (dly_in) @(posedge clock_in);
            w = mem.exists(addr_in) ? mem[addr_in] : pat(addr_in);
            for (int i = 0; i < 3; i++)
               if (write_in && lane_in[i])
                  w[i*8+:8] = wdata_in[i*8+:8];
            if (write_in)
               mem[addr_in] = w;
            valid_out <= 1'h1;
            rdata_out <= w;
            @(posedge clock_in);
            valid_out <= 1'h0;
            rdata_out <= ~w;
         end
         else
            rdata_out <= ~rdata_out; // Idle bus never holds a stale word
      end
   end
endmodule
`default_nettype wire
